// ---- rtl/atc_regs.svh ----
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH

// ************************************************************
// Register offsets (register port address space)
// ************************************************************
`define ATC_OFF_AMB0 10'h001
`define ATC_OFF_CTLA 10'h002
`define ATC_OFF_AMB1 10'h003
`define ATC_OFF_CTLC 10'h004
`define ATC_OFF_STAT 10'h005

// ************************************************************
// Field positions
// ************************************************************
`define ATC_SLOW_FP_MSB 13
`define ATC_SLOW_FP_LSB 12
`define ATC_SLOW_LP_MSB 15
`define ATC_SLOW_LP_LSB 14
`define ATC_FAST_SKIP_MSB 3
`define ATC_FAST_SKIP_LSB 0
`define ATC_ALLOW_BIT 15
`define ATC_APPR_MSB 5
`define ATC_APPR_LSB 0
`define ATC_UPD_MSB 7
`define ATC_UPD_LSB 6
`define ATC_HOVER_MSB 13
`define ATC_HOVER_LSB 8

// ************************************************************
// Reset values and fixed counts
// ************************************************************
`define ATC_RST_AMB0 16'h0000
`define ATC_RST_CTLA 16'h8000
`define ATC_RST_AMB1 16'h0804
`define ATC_RST_CTLC 16'h0000
`define ATC_FP_ZERO_LIMIT 2'h3

`endif

// ---- rtl/atc_pkg.sv ----
package atc_pkg;

    // Sequencer states
    typedef enum logic [0:0] {
        ATC_IDLE = 1'b0,
        ATC_CALC = 1'b1
    } atc_fsm_t;

    // One conversion sample
    typedef struct packed {
        logic [3:0] stage;
        logic [15:0] data;
    } atc_conv_t;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] addr;
        logic [15:0] wdata;
    } atc_regreq_t;

    // Per-stage record kept in stage memory
    typedef struct packed {
        logic [3:0][15:0] ff;
        logic [15:0] sf0;
        logic [15:0] sf1;
        logic [15:0] amb;
        logic [3:0] fcnt;
        logic [1:0] scnt;
    } atc_rec_t;

    // Whole state of the top module
    typedef struct packed {
        atc_fsm_t st;
        logic [15:0] amb0;
        logic [15:0] ctla;
        logic [15:0] amb1;
        logic [15:0] ctlc;
        logic [15:0] seen;
        logic [15:0] touch;
        atc_conv_t cur;
        logic [15:0] rdata;
        logic rvalid;
        logic conv_ready;
        logic res_valid;
        logic [3:0] res_stage;
        logic prox1;
        logic prox2;
        logic fast_push;
        logic slow_tick;
        logic amb_upd;
        logic [15:0] ambient;
        logic [15:0] thr_hi;
        logic [15:0] thr_lo;
        logic int_n;
    } atc_state_t;

endpackage : atc_pkg

// ---- rtl/atc_stage_ram.sv ----
module atc_stage_ram #(
    parameter int DW = 118,
    parameter int AW = 4
) (
    // Clock and enable
    input wire logic ref_clk,
    input wire logic ce,
    // Read side
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data,
    // Write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [DW-1:0] mem [0:(1<<AW)-1]; // One word per stage

    // Registered read, write-first is not needed: one access per stage
    always_ff @(posedge ref_clk) begin
        if (ce) begin
            rd_data <= mem[rd_addr];
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
        end
    end

endmodule : atc_stage_ram

// ---- rtl/atc_top.sv ----
// What this block does
// - Full-power slow skip at 0x001 bits 13:12
// - Low-power slow skip at 0x001 bits 15:14
// - Skipped samples never enter the slow FIFO
// - Full-power slow interval scales with fast interval
// - Low-power slow interval uses low-power skip plus one
// - Slow push only when change exceeds update threshold
// - Slow update needs allow bit and no proximity
// - Proximity one: fast word0 versus word3 difference
// - Proximity two: fast average versus ambient difference
// - Compensation runs on every conversion automatically
// - Host controls compensation through 0x001-0x003
// - Per-stage compensation data kept in RAM
// - Thresholds rewritten from tracked ambient
// - Thresholds scale offsets by sensitivity settings
// - Active-low interrupt when threshold crossed
// - Fast interval is fast skip plus one samples
// - Fast skip held at 0x002 bits 3:0
// - Proximity suspends calibration immediately
module atc_top
    import atc_pkg::*;
#(
    parameter int DW = 16,
    parameter int SENS_SHIFT = 4
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    // Register port from serial interface
    input wire atc_regreq_t reg_req,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Conversion samples from the converter sequencer
    input wire logic conv_valid,
    input wire atc_conv_t conv_in,
    output logic conv_ready,
    input wire logic low_power,
    // Threshold setup from stage configuration
    input wire logic [15:0] offset_high,
    input wire logic [15:0] offset_low,
    input wire logic [3:0] pos_sens,
    input wire logic [3:0] neg_sens,
    // Results
    output logic res_valid,
    output logic [3:0] res_stage,
    output logic prox1,
    output logic prox2,
    output logic [15:0] ambient,
    output logic [15:0] thr_hi,
    output logic [15:0] thr_lo,
    output logic int_n
);

`include "atc_regs.svh"

    // ************************************************************
    // Helpers
    // ************************************************************
    // Absolute difference, used by the proximity and update comparators
    function automatic logic [15:0] atc_absdiff(input logic [15:0] a, input logic [15:0] b);
        atc_absdiff = (a > b) ? (a - b) : (b - a);
    endfunction : atc_absdiff

    // ************************************************************
    // State and memory wiring
    // ************************************************************
    atc_state_t s_ff; // All state
    atc_state_t nxt_s; // Next state
    atc_rec_t rec_rd; // Record read from stage memory
    atc_rec_t rec_wr; // Record written back
    logic [$bits(atc_rec_t)-1:0] ram_rd; // Raw read word
    logic ram_we; // Write back strobe

    // Per-stage record store
    atc_stage_ram #(
        .DW($bits(atc_rec_t)),
        .AW(4)
    ) u_ram (
        .ref_clk(ref_clk),
        .ce(ce),
        .rd_addr(conv_in.stage),
        .rd_data(ram_rd),
        .wr_en(ram_we),
        .wr_addr(s_ff.cur.stage),
        .wr_data(rec_wr)
    );

    assign rec_rd = atc_rec_t'(ram_rd);

    // ************************************************************
    // Field decode
    // ************************************************************
    logic [1:0] slow_fp; // Full-power slow skip
    logic [1:0] slow_lp; // Low-power slow skip
    logic [3:0] fast_skip; // Fast skip setting
    logic allow; // Ambient update allow
    logic [5:0] appr_sens; // Approach sensitivity
    logic [1:0] upd_thr; // Ambient update threshold
    logic [5:0] hover_thr; // Hover threshold
    logic [1:0] slow_limit; // Fast pushes per slow tick, minus one

    assign slow_fp = s_ff.amb0[`ATC_SLOW_FP_MSB:`ATC_SLOW_FP_LSB];
    assign slow_lp = s_ff.amb0[`ATC_SLOW_LP_MSB:`ATC_SLOW_LP_LSB];
    assign fast_skip = s_ff.ctla[`ATC_FAST_SKIP_MSB:`ATC_FAST_SKIP_LSB];
    assign allow = s_ff.ctla[`ATC_ALLOW_BIT];
    assign appr_sens = s_ff.amb1[`ATC_APPR_MSB:`ATC_APPR_LSB];
    assign upd_thr = s_ff.amb1[`ATC_UPD_MSB:`ATC_UPD_LSB];
    assign hover_thr = s_ff.amb1[`ATC_HOVER_MSB:`ATC_HOVER_LSB];

    // Full power: 00 means four fast pushes per slow push, else field value
    // Low power: field plus one fast pushes per slow push
    always_comb begin
        if (low_power) begin
            slow_limit = slow_lp;
        end else if (slow_fp == 2'h0) begin
            slow_limit = `ATC_FP_ZERO_LIMIT;
        end else begin
            slow_limit = slow_fp - 2'h1;
        end
    end

    // ************************************************************
    // Stage computation
    // ************************************************************
    logic [15:0] d; // Sample under work
    logic do_fast; // Sample enters fast FIFO
    logic do_slow; // Slow FIFO slot reached
    logic p1; // Approach comparator
    logic p2; // Hover comparator
    logic prox_any; // Combined proximity
    logic do_upd; // Ambient update
    logic [17:0] fsum; // Fast FIFO sum
    logic [15:0] favg; // Fast FIFO average
    logic [16:0] asum; // Slow pair sum
    logic [15:0] oh4; // Offset high quarter
    logic [15:0] ol4; // Offset low quarter
    logic [19:0] hi_scale; // Scaled high term
    logic [19:0] lo_scale; // Scaled low term
    logic [15:0] hi_new; // New high threshold
    logic [15:0] lo_new; // New low threshold
    logic touch_now; // Threshold crossed

    always_comb begin
        d = s_ff.cur.data;
        rec_wr = rec_rd;
        do_fast = 1'b0;
        do_slow = 1'b0;
        // First sample of a stage seeds its record, nothing is compared yet
        if (!s_ff.seen[s_ff.cur.stage]) begin
            rec_wr.ff = {4{d}};
            rec_wr.sf0 = d;
            rec_wr.sf1 = d;
            rec_wr.amb = d;
            rec_wr.fcnt = 4'h0;
            rec_wr.scnt = 2'h0;
        end else if (rec_rd.fcnt >= fast_skip) begin
            // Fast slot: shift the fast FIFO
            do_fast = 1'b1;
            rec_wr.ff = {rec_rd.ff[2:0], d};
            rec_wr.fcnt = 4'h0;
            if (rec_rd.scnt >= slow_limit) begin
                do_slow = 1'b1;
                rec_wr.scnt = 2'h0;
            end else begin
                rec_wr.scnt = rec_rd.scnt + 2'h1;
            end
        end else begin
            rec_wr.fcnt = rec_rd.fcnt + 4'h1;
        end
        // Comparators on the updated fast FIFO
        fsum = {2'h0, rec_wr.ff[0]} + {2'h0, rec_wr.ff[1]} + {2'h0, rec_wr.ff[2]} + {2'h0, rec_wr.ff[3]};
        favg = fsum[17:2];
        p1 = atc_absdiff(rec_wr.ff[0], rec_wr.ff[3]) > {10'h000, appr_sens};
        p2 = atc_absdiff(favg, rec_wr.amb) > {10'h000, hover_thr};
        prox_any = p1 | p2;
        // Ambient tracking is frozen by any proximity
        do_upd = do_slow && allow && !prox_any
            && (atc_absdiff(d, rec_rd.sf0) > {14'h0000, upd_thr});
        asum = {1'b0, rec_rd.sf0} + {1'b0, d};
        if (do_upd) begin
            rec_wr.sf1 = rec_rd.sf0;
            rec_wr.sf0 = d;
            rec_wr.amb = asum[16:1];
        end
        // Thresholds follow the tracked ambient; wraps are not clamped
        oh4 = offset_high >> 2;
        ol4 = offset_low >> 2;
        hi_scale = ({4'h0, oh4} * {16'h0000, pos_sens}) >> SENS_SHIFT;
        lo_scale = ({4'h0, offset_low - ol4} * {16'h0000, neg_sens}) >> SENS_SHIFT;
        hi_new = rec_wr.amb + oh4 + hi_scale[15:0];
        lo_new = rec_wr.amb - ol4 - lo_scale[15:0];
        touch_now = s_ff.seen[s_ff.cur.stage] && ((d > hi_new) || (d < lo_new));
    end

    assign ram_we = ce && (s_ff.st == ATC_CALC);

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        nxt_s = s_ff;
        nxt_s.rvalid = 1'b0;
        nxt_s.res_valid = 1'b0;
        // Register writes, host setup path
        if (reg_req.wr) begin
            case (reg_req.addr)
                `ATC_OFF_AMB0: begin
                    nxt_s.amb0 = reg_req.wdata;
                end
                `ATC_OFF_CTLA: begin
                    nxt_s.ctla = reg_req.wdata;
                end
                `ATC_OFF_AMB1: begin
                    nxt_s.amb1 = reg_req.wdata;
                end
                `ATC_OFF_CTLC: begin
                    nxt_s.ctlc = reg_req.wdata;
                end
                default: begin
                    nxt_s.amb0 = s_ff.amb0;
                end
            endcase
        end
        // Register reads, unmapped reads give zero
        if (reg_req.rd) begin
            nxt_s.rvalid = 1'b1;
            case (reg_req.addr)
                `ATC_OFF_AMB0: begin
                    nxt_s.rdata = s_ff.amb0;
                end
                `ATC_OFF_CTLA: begin
                    nxt_s.rdata = s_ff.ctla;
                end
                `ATC_OFF_AMB1: begin
                    nxt_s.rdata = s_ff.amb1;
                end
                `ATC_OFF_CTLC: begin
                    nxt_s.rdata = s_ff.ctlc;
                end
                `ATC_OFF_STAT: begin
                    nxt_s.rdata = {s_ff.res_stage, 5'h00, !s_ff.int_n, s_ff.amb_upd,
                        s_ff.slow_tick, s_ff.fast_push, s_ff.prox1 | s_ff.prox2, s_ff.prox2, s_ff.prox1};
                end
                default: begin
                    nxt_s.rdata = 16'h0000;
                end
            endcase
        end
        // Conversion sequencing, one sample per two cycles
        case (s_ff.st)
            ATC_IDLE: begin
                if (conv_valid) begin
                    nxt_s.cur = conv_in;
                    nxt_s.st = ATC_CALC;
                    nxt_s.conv_ready = 1'b0;
                end
            end
            ATC_CALC: begin
                nxt_s.st = ATC_IDLE;
                nxt_s.conv_ready = 1'b1;
                nxt_s.seen[s_ff.cur.stage] = 1'b1;
                nxt_s.touch[s_ff.cur.stage] = touch_now;
                nxt_s.res_valid = 1'b1;
                nxt_s.res_stage = s_ff.cur.stage;
                nxt_s.prox1 = p1;
                nxt_s.prox2 = p2;
                nxt_s.fast_push = do_fast;
                nxt_s.slow_tick = do_slow;
                nxt_s.amb_upd = do_upd;
                nxt_s.ambient = rec_wr.amb;
                nxt_s.thr_hi = hi_new;
                nxt_s.thr_lo = lo_new;
            end
            default: begin
                nxt_s.st = ATC_IDLE;
            end
        endcase
        // Interrupt low while any stage sits beyond a threshold
        nxt_s.int_n = ~|nxt_s.touch;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s_ff <= '0;
            s_ff.st <= ATC_IDLE;
            s_ff.amb0 <= `ATC_RST_AMB0;
            s_ff.ctla <= `ATC_RST_CTLA;
            s_ff.amb1 <= `ATC_RST_AMB1;
            s_ff.ctlc <= `ATC_RST_CTLC;
            s_ff.conv_ready <= 1'b1;
            s_ff.int_n <= 1'b1;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata = s_ff.rdata;
    assign reg_rvalid = s_ff.rvalid;
    assign conv_ready = s_ff.conv_ready;
    assign res_valid = s_ff.res_valid;
    assign res_stage = s_ff.res_stage;
    assign prox1 = s_ff.prox1;
    assign prox2 = s_ff.prox2;
    assign ambient = s_ff.ambient;
    assign thr_hi = s_ff.thr_hi;
    assign thr_lo = s_ff.thr_lo;
    assign int_n = s_ff.int_n;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_upd_gate;
        @(posedge ref_clk) disable iff (!resetn)
        (s_ff.res_valid && s_ff.amb_upd) |-> (!s_ff.prox1 && !s_ff.prox2 && $past(s_ff.ctla[`ATC_ALLOW_BIT]));
    endproperty
    a_upd_gate: assert property (p_upd_gate) else $error("ambient updated under proximity");

    property p_prox_block;
        @(posedge ref_clk) disable iff (!resetn)
        (s_ff.res_valid && (s_ff.prox1 || s_ff.prox2)) |-> !s_ff.amb_upd;
    endproperty
    a_prox_block: assert property (p_prox_block) else $error("calibration not suspended");

    property p_slow_from_fast;
        @(posedge ref_clk) disable iff (!resetn)
        s_ff.slow_tick |-> s_ff.fast_push;
    endproperty
    a_slow_from_fast: assert property (p_slow_from_fast) else $error("slow slot without fast slot");

    property p_upd_needs_slot;
        @(posedge ref_clk) disable iff (!resetn)
        s_ff.amb_upd |-> s_ff.slow_tick;
    endproperty
    a_upd_needs_slot: assert property (p_upd_needs_slot) else $error("ambient updated off slot");

    property p_int_level;
        @(posedge ref_clk) disable iff (!resetn)
        s_ff.int_n == !(|s_ff.touch);
    endproperty
    a_int_level: assert property (p_int_level) else $error("interrupt disagrees with touch");

    property p_result_time;
        @(posedge ref_clk) disable iff (!resetn)
        (ce && conv_ready && conv_valid) ##1 ce |=> (res_valid && res_stage == $past(conv_in.stage, 2));
    endproperty
    a_result_time: assert property (p_result_time) else $error("sample result missing");

    property p_ctl_write;
        @(posedge ref_clk) disable iff (!resetn)
        (ce && reg_req.wr && reg_req.addr == `ATC_OFF_AMB0) |=> (slow_fp == $past(reg_req.wdata[13:12]));
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("slow skip write lost");

    property p_fast_write;
        @(posedge ref_clk) disable iff (!resetn)
        (ce && reg_req.wr && reg_req.addr == `ATC_OFF_CTLA) |=> (fast_skip == $past(reg_req.wdata[3:0]));
    endproperty
    a_fast_write: assert property (p_fast_write) else $error("fast skip write lost");

    property p_ready_back;
        @(posedge ref_clk) disable iff (!resetn)
        (ce && !conv_ready) |=> conv_ready;
    endproperty
    a_ready_back: assert property (p_ready_back) else $error("sequencer stuck busy");

endmodule : atc_top

// ---- verif/atc_conv_src.sv ----
// ************************************************************
// Converter sequencer stand-in: offers one sample per start
// ************************************************************
module atc_conv_src
    import atc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Command from the bench
    input wire logic start,
    input wire atc_conv_t smp,
    // Sample offer toward the block
    output logic conv_valid,
    output atc_conv_t conv_in,
    input wire logic conv_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    // Offer held until taken; data scrambled once released
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            conv_valid <= 1'b0;
            conv_in <= '0;
        end else if (conv_valid && conv_ready) begin
            // Inverse of last value, so a stale read cannot pass
            conv_valid <= 1'b0;
            conv_in <= ~conv_in;
        end else if (!conv_valid && start) begin
            // Every conversion goes on to the block
            conv_valid <= 1'b1;
            conv_in <= smp;
        end
    end
endmodule : atc_conv_src

// ---- verif/test_ambient_tracking_calibration.sv ----
`include "atc_regs.svh"
module test_ambient_tracking_calibration
    import atc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Signals
    // ************************************************************
    logic ref_clk = 1'b0;
    logic resetn;
    atc_regreq_t reg_req;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    logic conv_valid;
    atc_conv_t conv_in;
    logic conv_ready;
    logic low_power;
    logic [15:0] offset_high, offset_low;
    logic [3:0] pos_sens, neg_sens;
    logic res_valid, prox1, prox2, int_n;
    logic [3:0] res_stage;
    logic [15:0] ambient, thr_hi, thr_lo, st;
    logic start, ce;
    atc_conv_t smp;
    int miscompares, num_checks, cnt;

    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    atc_top uut (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .conv_valid(conv_valid), .conv_in(conv_in), .conv_ready(conv_ready),
        .low_power(low_power), .offset_high(offset_high), .offset_low(offset_low), .pos_sens(pos_sens),
        .neg_sens(neg_sens), .res_valid(res_valid), .res_stage(res_stage), .prox1(prox1), .prox2(prox2),
        .ambient(ambient), .thr_hi(thr_hi), .thr_lo(thr_lo), .int_n(int_n));

    atc_conv_src src (.ref_clk(ref_clk), .resetn(resetn), .start(start), .smp(smp),
        .conv_valid(conv_valid), .conv_in(conv_in), .conv_ready(conv_ready));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Hung handshake ends the run
    task automatic hung(input string what);
        miscompares++;
        $display("[ERR] %s expected 1 seen 0", what);
        results();
    endtask : hung

    task automatic reg_wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        reg_req <= '0;
    endtask : reg_wr

    // Read data is taken in the cycle reg_rvalid stands
    task automatic reg_rd(input logic [9:0] a, output logic [15:0] d);
        int n;
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge ref_clk);
        reg_req <= '0;
        #1;
        n = 0;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n == 4) hung("reg_rvalid");
        d = reg_rdata;
    endtask : reg_rd

    // One sample through the partner, wait for its result
    task automatic conv(input logic [3:0] s, input logic [15:0] d);
        int n;
        @(posedge ref_clk);
        start <= 1'b1;
        smp <= '{stage: s, data: d};
        @(posedge ref_clk);
        start <= 1'b0;
        #1;
        n = 0;
        while (res_valid !== 1'b1 && n < 10) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n == 10) hung("res_valid");
    endtask : conv

    // Expected thresholds from ambient and offsets
    function automatic logic [15:0] e_hi(input logic [15:0] a);
        e_hi = a + (offset_high >> 2) + (((offset_high >> 2) * pos_sens) >> 4);
    endfunction : e_hi

    function automatic logic [15:0] e_lo(input logic [15:0] a);
        e_lo = a - (offset_low >> 2) - (((offset_low - (offset_low >> 2)) * neg_sens) >> 4);
    endfunction : e_lo

    // Count status bit b over n samples of constant value
    task automatic tally(input logic [3:0] s, input int b, input int n);
        cnt = 0;
        repeat (n) begin
            conv(s, 16'h1000);
            reg_rd(`ATC_OFF_STAT, st);
            if (st[b] === 1'b1) cnt++;
        end
    endtask : tally

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs;
        reg_rd(`ATC_OFF_AMB0, st); chk("amb0 reset", `ATC_RST_AMB0, st);
        reg_rd(`ATC_OFF_CTLA, st); chk("ctla reset", `ATC_RST_CTLA, st);
        reg_rd(`ATC_OFF_AMB1, st); chk("amb1 reset", `ATC_RST_AMB1, st);
        reg_rd(`ATC_OFF_CTLC, st); chk("ctlc reset", `ATC_RST_CTLC, st);
        reg_rd(10'h3ff, st); chk("unmapped", 16'h0000, st);
        reg_wr(`ATC_OFF_AMB0, 16'h6000);
        reg_rd(`ATC_OFF_AMB0, st);
        chk("fp skip field", 16'h0002, {14'h0, st[13:12]});
        chk("lp skip field", 16'h0001, {14'h0, st[15:14]});
        reg_wr(`ATC_OFF_AMB0, 16'h0000);
        ce <= 1'b0;
        reg_wr(`ATC_OFF_CTLC, 16'h00ff);
        ce <= 1'b1;
        reg_rd(`ATC_OFF_CTLC, st); chk("ce freeze", `ATC_RST_CTLC, st);
        $display("test regs done");
    endtask : t_regs

    task automatic t_seed;
        conv(4'h0, 16'h1000);
        chk("stage", 16'h0000, {12'h0, res_stage});
        chk("ambient", 16'h1000, ambient);
        chk("thr_hi", e_hi(16'h1000), thr_hi);
        chk("thr_lo", e_lo(16'h1000), thr_lo);
        chk("int_n", 16'h0001, {15'h0, int_n});
        $display("test seed done");
    endtask : t_seed

    task automatic t_prox;
        conv(4'h1, 16'h1000);
        conv(4'h1, 16'h1008);
        chk("prox1", 16'h0001, {15'h0, prox1});
        chk("prox2", 16'h0000, {15'h0, prox2});
        chk("ambient held", 16'h1000, ambient);
        reg_rd(`ATC_OFF_STAT, st); chk("status prox", 16'h0005, {13'h0, st[2:0]});
        reg_wr(`ATC_OFF_AMB1, 16'h023f);
        conv(4'h2, 16'h2000);
        conv(4'h2, 16'h2010);
        chk("prox1", 16'h0000, {15'h0, prox1});
        chk("prox2", 16'h0001, {15'h0, prox2});
        reg_rd(`ATC_OFF_STAT, st); chk("status prox", 16'h0006, {13'h0, st[2:0]});
        $display("test prox done");
    endtask : t_prox

    task automatic t_int;
        reg_wr(`ATC_OFF_AMB1, 16'h3f3f);
        conv(4'h3, 16'h1000);
        conv(4'h3, 16'h1100); chk("int_n high cross", 16'h0000, {15'h0, int_n});
        conv(4'h3, 16'h1000); chk("int_n inside", 16'h0001, {15'h0, int_n});
        conv(4'h3, 16'h0e00); chk("int_n low cross", 16'h0000, {15'h0, int_n});
        conv(4'h3, 16'h1000); chk("int_n inside", 16'h0001, {15'h0, int_n});
        $display("test int done");
    endtask : t_int

    task automatic t_track;
        low_power <= 1'b1;
        conv(4'h4, 16'h1000);
        for (int i = 0; i < 4 && ambient === 16'h1000; i++) conv(4'h4, 16'h1008);
        chk("ambient update", 16'h1004, ambient);
        chk("thr_hi follows", e_hi(16'h1004), thr_hi);
        reg_wr(`ATC_OFF_AMB1, 16'h3fff);
        repeat (4) conv(4'h4, 16'h1007);
        chk("below level", 16'h1004, ambient);
        reg_wr(`ATC_OFF_AMB1, 16'h3f3f);
        reg_wr(`ATC_OFF_CTLA, 16'h0000);
        repeat (4) conv(4'h4, 16'h1020);
        chk("allow off", 16'h1004, ambient);
        reg_wr(`ATC_OFF_CTLA, 16'h8000);
        for (int i = 0; i < 4 && ambient === 16'h1004; i++) conv(4'h4, 16'h1020);
        chk("allow on", 16'h1014, ambient);
        conv(4'h4, 16'h1200);
        chk("prox freeze", 16'h1014, ambient);
        $display("test track done");
    endtask : t_track

    task automatic t_skip;
        low_power <= 1'b0;
        reg_wr(`ATC_OFF_CTLA, 16'h8001);
        reg_rd(`ATC_OFF_CTLA, st); chk("fast skip field", 16'h0001, {12'h0, st[3:0]});
        conv(4'h5, 16'h1000);
        tally(4'h5, 3, 4); chk("fast pushes", 16'h0002, cnt[15:0]);
        reg_wr(`ATC_OFF_CTLA, 16'h8000);
        reg_wr(`ATC_OFF_AMB0, 16'h0000);
        conv(4'h6, 16'h1000);
        tally(4'h6, 4, 8); chk("fp slow slots", 16'h0002, cnt[15:0]);
        reg_wr(`ATC_OFF_AMB0, 16'h2000);
        tally(4'h6, 4, 8); chk("fp2 slow slots", 16'h0004, cnt[15:0]);
        low_power <= 1'b1;
        reg_wr(`ATC_OFF_AMB0, 16'h4000);
        tally(4'h6, 4, 8); chk("lp slow slots", 16'h0004, cnt[15:0]);
        $display("test skip done");
    endtask : t_skip

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        resetn = 1'b0;
        reg_req = '0;
        start = 1'b0;
        ce = 1'b1;
        smp = '0;
        low_power = 1'b0;
        offset_high = 16'h0100;
        offset_low = 16'h0100;
        pos_sens = 4'h4;
        neg_sens = 4'h8;
        miscompares = 0;
        num_checks = 0;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        t_regs();
        t_seed();
        t_prox();
        t_int();
        t_track();
        t_skip();
        results();
    end
endmodule : test_ambient_tracking_calibration
